// [rtl/fmdc_pkg.sv]
package fmdc_pkg;
  localparam logic [7:0] CMD_SET_FIELD_MARGIN = 8'h0e;
  localparam logic [7:0] CMD_DF_ERASE_VERIFY = 8'h10;
  localparam logic [7:0] CMD_DF_PROGRAM = 8'h11;
  localparam logic [2:0] IDX_CODE = 3'h0;
  localparam logic [2:0] IDX_ADDR = 3'h1;
  localparam logic [2:0] IDX_WORD0 = 3'h2;
  localparam logic [2:0] IDX_COUNT = 3'h2;
  localparam logic [2:0] IDX_WORD3 = 3'h5;
  localparam logic [2:0] IDX_MARGIN = 3'h1;
  localparam logic [15:0] MARGIN_NORMAL = 16'h0000;
  localparam logic [15:0] MARGIN_USER1 = 16'h0001;
  localparam logic [15:0] MARGIN_USER0 = 16'h0002;
  localparam logic [15:0] MARGIN_FIELD1 = 16'h0003;
  localparam logic [15:0] MARGIN_FIELD0 = 16'h0004;
  // block select codes, data-flash geometry, erased word, bias and availability bit indices
  localparam logic [6:0] DF_BLOCK_ID = 7'h10;
  localparam logic [6:0] PF_BLOCK_ID = 7'h7f;
  localparam logic [15:0] DF_LAST_ADDR = 16'h0fff;
  localparam int PROT_LSB = 9;
  localparam int PROT_W = 3;
  localparam logic [15:0] ERASED_WORD = 16'hffff;
  localparam int BIAS_PF = 0;
  localparam int BIAS_DF = 1;
  localparam int AVAIL_MARGIN = 0;
  localparam int AVAIL_EVERIFY = 1;
  localparam int AVAIL_PROGRAM = 2;

  typedef logic [5:0][15:0] fmdc_params_t;
  typedef enum logic [2:0] {
    FMDC_LVL_NORMAL, FMDC_LVL_USER1, FMDC_LVL_USER0, FMDC_LVL_FIELD1, FMDC_LVL_FIELD0
  } fmdc_level_e;
  typedef enum logic [2:0] {FMDC_IDLE, FMDC_DECODE, FMDC_ISSUE, FMDC_WAIT, FMDC_DONE} fmdc_state_e;
  typedef struct packed {
    logic req;
    logic write;
    logic [15:0] addr;
    logic [15:0] wdata;
  } fmdc_mem_req_s;
  typedef struct packed {
    logic ack;
    logic [15:0] rdata;
    logic err;
    logic fatal;
  } fmdc_mem_rsp_s;
  typedef struct packed {
    logic cmd_complete_flag;
    logic access_error_flag;
    logic protect_violation_flag;
    logic verify_error_flag;
    logic verify_fatal_flag;
  } fmdc_flags_s;
  typedef struct packed {
    fmdc_state_e st;
    logic [7:0] cmd;
    logic [15:0] addr;
    logic [15:0] left;
    logic [1:0] widx;
    logic [2:0] nw;
    logic vfy;
    fmdc_mem_req_s mem;
    fmdc_flags_s flags;
    fmdc_level_e pf_lvl;
    fmdc_level_e df_lvl;
    logic [1:0] bias_erased;
    logic [1:0] bias_prog;
  } fmdc_regs_s;
endpackage : fmdc_pkg

// [rtl/fmdc_seq.sv]
`timescale 1ns/1ns
module fmdc_seq (
  input wire logic CLK, // 50 MHz module clock
  input wire logic RST, // synchronous reset, active high
  input wire logic LAUNCH, // pulse: software clears the complete flag
  input wire logic CLEAR_ERRORS, // pulse: clears access and protect flags
  input wire logic [2:0] PARAM_INDEX, // cmd_param_index
  input wire fmdc_pkg::fmdc_params_t PARAM_ARRAY, // cmd_param_array words 0..5
  input wire logic SPECIAL_MODE, // chip is in a special mode
  input wire logic [2:0] CMD_AVAIL, // availability: margin, erase verify, program
  input wire logic [7:0] DF_PROTECT, // one bit per protected data-flash region
  input wire fmdc_pkg::fmdc_mem_rsp_s MEM_RSP, // array answer
  output fmdc_pkg::fmdc_mem_req_s MEM_REQ, // array request
  output fmdc_pkg::fmdc_flags_s FLAGS, // flash_status_reg bits
  output fmdc_pkg::fmdc_level_e PF_LEVEL, // program-flash read margin
  output fmdc_pkg::fmdc_level_e DF_LEVEL, // data-flash read margin
  output logic [1:0] BIAS_ERASED, // per block: reads biased toward erased
  output logic [1:0] BIAS_PROG // per block: reads biased toward programmed
);
  import fmdc_pkg::*;

  fmdc_regs_s r;
  fmdc_regs_s next_r;

  function automatic logic fmdc_fits(input logic [15:0] a, input logic [15:0] n);
    logic [17:0] e;
    e = {2'b00, a} + {1'b0, n, 1'b0};
    return (a <= DF_LAST_ADDR) && (e <= ({2'b00, DF_LAST_ADDR} + 18'h1));
  endfunction : fmdc_fits

  // a group of at most four words spans at most two regions
  function automatic logic fmdc_prot(input logic [7:0] map, input logic [15:0] a,
                                     input logic [2:0] n);
    logic [15:0] l;
    l = a + {12'h000, n - 3'h1, 1'b0};
    return map[a[PROT_LSB +: PROT_W]] | map[l[PROT_LSB +: PROT_W]];
  endfunction : fmdc_prot

  function automatic fmdc_level_e fmdc_to_level(input logic [15:0] s);
    case (s)
      MARGIN_USER1: return FMDC_LVL_USER1;
      MARGIN_USER0: return FMDC_LVL_USER0;
      MARGIN_FIELD1: return FMDC_LVL_FIELD1;
      MARGIN_FIELD0: return FMDC_LVL_FIELD0;
      default: return FMDC_LVL_NORMAL;
    endcase
  endfunction : fmdc_to_level

  // parameters are read live in decode and during execution
  logic [7:0] code;
  logic [6:0] blk;
  logic [15:0] gaddr;
  logic [15:0] setting;
  logic [2:0] nw;
  logic dec_margin;
  logic dec_ev;
  logic dec_pgm;
  logic margin_err;
  logic ev_err;
  logic pgm_err;
  logic pgm_prot;
  logic rd_ok;

  assign code = PARAM_ARRAY[IDX_CODE][15:8];
  assign blk = PARAM_ARRAY[IDX_CODE][6:0];
  assign gaddr = PARAM_ARRAY[IDX_ADDR];
  assign setting = PARAM_ARRAY[IDX_MARGIN];
  assign nw = PARAM_INDEX - 3'h1;
  assign dec_margin = (r.st == FMDC_DECODE) && (code == CMD_SET_FIELD_MARGIN);
  assign dec_ev = (r.st == FMDC_DECODE) && (code == CMD_DF_ERASE_VERIFY);
  assign dec_pgm = (r.st == FMDC_DECODE) && (code == CMD_DF_PROGRAM);
  assign margin_err = (PARAM_INDEX != IDX_MARGIN) || !CMD_AVAIL[AVAIL_MARGIN]
                      || !SPECIAL_MODE || ((blk != DF_BLOCK_ID) && (blk != PF_BLOCK_ID))
                      || (setting > MARGIN_FIELD0);
  assign ev_err = (PARAM_INDEX != IDX_COUNT) || !CMD_AVAIL[AVAIL_EVERIFY]
                  || (blk != DF_BLOCK_ID) || gaddr[0]
                  || !fmdc_fits(gaddr, PARAM_ARRAY[IDX_COUNT]);
  assign pgm_err = (PARAM_INDEX < IDX_WORD0) || (PARAM_INDEX > IDX_WORD3)
                   || !CMD_AVAIL[AVAIL_PROGRAM] || (blk != DF_BLOCK_ID) || gaddr[0]
                   || !fmdc_fits(gaddr, {13'h0000, nw});
  assign pgm_prot = fmdc_prot(DF_PROTECT, gaddr, nw);
  assign rd_ok = r.vfy ? (MEM_RSP.rdata == PARAM_ARRAY[3'(IDX_WORD0 + {1'b0, r.widx})])
                       : (MEM_RSP.rdata == ERASED_WORD);

  always_comb begin
    next_r = r;
    if (CLEAR_ERRORS) begin
      next_r.flags.access_error_flag = 1'b0;
      next_r.flags.protect_violation_flag = 1'b0;
    end
    case (r.st)
      FMDC_IDLE: begin
        // a launch while busy is ignored; the complete flag is already low
        if (LAUNCH && r.flags.cmd_complete_flag) begin
          next_r.flags.cmd_complete_flag = 1'b0;
          next_r.flags.verify_error_flag = 1'b0;
          next_r.flags.verify_fatal_flag = 1'b0;
          next_r.st = FMDC_DECODE;
        end
      end
      FMDC_DECODE: begin
        next_r.cmd = code;
        next_r.addr = gaddr;
        next_r.widx = 2'b00;
        next_r.vfy = 1'b0;
        next_r.st = FMDC_DONE;
        if (dec_margin) begin
          if (margin_err) begin
            next_r.flags.access_error_flag = 1'b1;
          end else if (blk == DF_BLOCK_ID) begin
            next_r.df_lvl = fmdc_to_level(setting);
            next_r.bias_erased[BIAS_DF] = (setting == MARGIN_USER1)
                                          || (setting == MARGIN_FIELD1);
            next_r.bias_prog[BIAS_DF] = (setting == MARGIN_USER0)
                                        || (setting == MARGIN_FIELD0);
          end else begin
            next_r.pf_lvl = fmdc_to_level(setting);
            next_r.bias_erased[BIAS_PF] = (setting == MARGIN_USER1)
                                          || (setting == MARGIN_FIELD1);
            next_r.bias_prog[BIAS_PF] = (setting == MARGIN_USER0)
                                        || (setting == MARGIN_FIELD0);
          end
        end else if (dec_ev) begin
          if (ev_err) begin
            next_r.flags.access_error_flag = 1'b1;
          end else if (PARAM_ARRAY[IDX_COUNT] != 16'h0000) begin
            next_r.left = PARAM_ARRAY[IDX_COUNT];
            next_r.vfy = 1'b0;
            next_r.st = FMDC_ISSUE;
          end
        end else if (dec_pgm) begin
          if (pgm_err) begin
            next_r.flags.access_error_flag = 1'b1;
          end else if (pgm_prot) begin
            next_r.flags.protect_violation_flag = 1'b1;
          end else begin
            next_r.nw = nw;
            next_r.left = {13'h0000, nw};
            next_r.st = FMDC_ISSUE;
          end
        end else begin
          // codes outside this block are refused here
          next_r.flags.access_error_flag = 1'b1;
        end
      end
      FMDC_ISSUE: begin
        next_r.mem.req = 1'b1;
        next_r.mem.write = (r.cmd == CMD_DF_PROGRAM) && !r.vfy;
        next_r.mem.addr = r.addr;
        next_r.mem.wdata = PARAM_ARRAY[3'(IDX_WORD0 + {1'b0, r.widx})];
        next_r.st = FMDC_WAIT;
      end
      FMDC_WAIT: begin
        if (MEM_RSP.ack) begin
          next_r.mem.req = 1'b0;
          next_r.mem.write = 1'b0;
          if (!r.mem.write) begin
            if (MEM_RSP.err || !rd_ok) begin
              next_r.flags.verify_error_flag = 1'b1;
            end
            if (MEM_RSP.fatal) begin
              next_r.flags.verify_fatal_flag = 1'b1;
            end
          end
          next_r.addr = r.addr + 16'h0002;
          next_r.widx = r.widx + 2'b01;
          next_r.left = r.left - 16'h0001;
          next_r.st = FMDC_ISSUE;
          if (r.left == 16'h0001) begin
            if ((r.cmd == CMD_DF_PROGRAM) && !r.vfy) begin
              // second pass reads back what was just written
              next_r.vfy = 1'b1;
              next_r.addr = gaddr;
              next_r.widx = 2'b00;
              next_r.left = {13'h0000, r.nw};
            end else begin
              next_r.st = FMDC_DONE;
            end
          end
        end
      end
      FMDC_DONE: begin
        next_r.flags.cmd_complete_flag = 1'b1;
        next_r.st = FMDC_IDLE;
      end
      default: begin
        next_r.st = FMDC_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RST) begin
      r <= '0;
      r.flags.cmd_complete_flag <= 1'b1;
      r.st <= FMDC_IDLE;
      r.pf_lvl <= FMDC_LVL_NORMAL;
      r.df_lvl <= FMDC_LVL_NORMAL;
    end else begin
      r <= next_r;
    end
  end

  assign MEM_REQ = r.mem;
  assign FLAGS = r.flags;
  assign PF_LEVEL = r.pf_lvl;
  assign DF_LEVEL = r.df_lvl;
  assign BIAS_ERASED = r.bias_erased;
  assign BIAS_PROG = r.bias_prog;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  property p_margin_special;
    dec_margin && !SPECIAL_MODE |=> FLAGS.access_error_flag ##1 FLAGS.cmd_complete_flag;
  endproperty
  a_margin_special: assert property (p_margin_special) else $error("margin ran outside special");
  property p_margin_done;
    dec_margin && !margin_err && (blk == DF_BLOCK_ID) && (setting == MARGIN_FIELD1)
      |=> (DF_LEVEL == FMDC_LVL_FIELD1) ##1 FLAGS.cmd_complete_flag;
  endproperty
  a_margin_done: assert property (p_margin_done) else $error("field margin not applied");
  property p_margin_bad;
    dec_margin && (setting > MARGIN_FIELD0) |=> FLAGS.access_error_flag && $stable(DF_LEVEL);
  endproperty
  a_margin_bad: assert property (p_margin_bad) else $error("bad margin setting taken");
  property p_bias;
    BIAS_ERASED[BIAS_DF] == ((DF_LEVEL == FMDC_LVL_USER1) || (DF_LEVEL == FMDC_LVL_FIELD1));
  endproperty
  a_bias: assert property (p_bias) else $error("erased bias does not match level");
  property p_margin_noflags;
    dec_margin |=> !$rose(FLAGS.protect_violation_flag) && !$rose(FLAGS.verify_error_flag);
  endproperty
  a_margin_noflags: assert property (p_margin_noflags) else $error("margin set wrong flag");
  property p_ev_index;
    dec_ev && (PARAM_INDEX != IDX_COUNT) |=> FLAGS.access_error_flag && !MEM_REQ.req;
  endproperty
  a_ev_index: assert property (p_ev_index) else $error("erase verify index not refused");
  property p_read_err;
    (r.st == FMDC_WAIT) && MEM_RSP.ack && !MEM_REQ.write && MEM_RSP.fatal
      |=> FLAGS.verify_fatal_flag;
  endproperty
  a_read_err: assert property (p_read_err) else $error("fatal read not flagged");
  property p_pgm_prot;
    dec_pgm && !pgm_err && pgm_prot
      |=> FLAGS.protect_violation_flag && !MEM_REQ.req ##1 FLAGS.cmd_complete_flag;
  endproperty
  a_pgm_prot: assert property (p_pgm_prot) else $error("protected program went on");
  property p_pgm_range;
    dec_pgm && (PARAM_INDEX > IDX_WORD3) |=> FLAGS.access_error_flag;
  endproperty
  a_pgm_range: assert property (p_pgm_range) else $error("program index not refused");
  property p_unavail;
    dec_pgm && !CMD_AVAIL[AVAIL_PROGRAM] |=> FLAGS.access_error_flag [*2];
  endproperty
  a_unavail: assert property (p_unavail) else $error("unavailable program ran");

  c_margin: cover property (dec_margin && !margin_err ##2 FLAGS.cmd_complete_flag);
  c_ev_done: cover property (dec_ev && !ev_err ##[4:60] FLAGS.cmd_complete_flag);
  c_pgm_vfy: cover property (dec_pgm && !pgm_err && !pgm_prot ##[6:60] r.vfy);
  c_prot: cover property (dec_pgm && pgm_prot && !pgm_err);
endmodule : fmdc_seq

// [verification/fmdc_seq_tb.sv]
`timescale 1ns/1ns
module fmdc_seq_tb;
  import fmdc_pkg::*;
  logic CLK = 1'b0;
  logic RST = 1'b1;
  logic LAUNCH = 1'b0;
  logic CLEAR_ERRORS = 1'b0;
  logic [2:0] PARAM_INDEX = 3'h0;
  fmdc_params_t PARAM_ARRAY = '0;
  logic SPECIAL_MODE = 1'b1;
  logic [2:0] CMD_AVAIL = 3'h7;
  logic [7:0] DF_PROTECT = 8'h00;
  fmdc_mem_rsp_s MEM_RSP = '0;
  fmdc_mem_req_s MEM_REQ;
  fmdc_flags_s FLAGS;
  fmdc_level_e PF_LEVEL;
  fmdc_level_e DF_LEVEL;
  logic [1:0] BIAS_ERASED;
  logic [1:0] BIAS_PROG;
  int errors = 0;
  int total_checks = 0;
  logic [15:0] mem [0:2047];
  int lat = 0;
  int wcnt = 0;
  int nrd = 0;
  int nwr = 0;
  logic err_inj = 1'b0;
  logic fatal_inj = 1'b0;
  logic [15:0] last_rd = 16'h0;

  fmdc_seq u_fmdc_seq (.CLK(CLK), .RST(RST), .LAUNCH(LAUNCH), .CLEAR_ERRORS(CLEAR_ERRORS),
    .PARAM_INDEX(PARAM_INDEX), .PARAM_ARRAY(PARAM_ARRAY), .SPECIAL_MODE(SPECIAL_MODE),
    .CMD_AVAIL(CMD_AVAIL), .DF_PROTECT(DF_PROTECT), .MEM_RSP(MEM_RSP), .MEM_REQ(MEM_REQ),
    .FLAGS(FLAGS), .PF_LEVEL(PF_LEVEL), .DF_LEVEL(DF_LEVEL), .BIAS_ERASED(BIAS_ERASED),
    .BIAS_PROG(BIAS_PROG));

  always #10 CLK = ~CLK;

  // array stand-in: acks after lat idle cycles; released data is inverted so stale reads show
  always @(posedge CLK) begin
    #1;
    if (MEM_RSP.ack) begin
      MEM_RSP.ack = 1'b0;
      MEM_RSP.err = 1'b0;
      MEM_RSP.fatal = 1'b0;
      MEM_RSP.rdata = ~MEM_RSP.rdata;
      wcnt = 0;
    end else if (MEM_REQ.req && wcnt < lat) begin
      wcnt++;
    end else if (MEM_REQ.req && MEM_REQ.write) begin
      mem[MEM_REQ.addr[11:1]] = MEM_REQ.wdata;
      nwr++;
      MEM_RSP.ack = 1'b1;
    end else if (MEM_REQ.req) begin
      MEM_RSP = '{1'b1, mem[MEM_REQ.addr[11:1]], err_inj, fatal_inj};
      last_rd = MEM_REQ.addr;
      nrd++;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic stop_test();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : stop_test

  // words 3..5 are set by the caller; parameters held untouched until complete
  task automatic run(input logic [7:0] code, input logic [6:0] blk, input logic [15:0] a,
                     input logic [15:0] b, input logic [2:0] idx);
    int n;
    CLEAR_ERRORS = 1'b1;
    PARAM_ARRAY[0] = {code, 1'b0, blk};
    PARAM_ARRAY[1] = a;
    PARAM_ARRAY[2] = b;
    PARAM_INDEX = idx;
    nrd = 0;
    nwr = 0;
    @(posedge CLK);
    #1;
    CLEAR_ERRORS = 1'b0;
    LAUNCH = 1'b1;
    @(posedge CLK);
    #1;
    LAUNCH = 1'b0;
    n = 0;
    do begin
      @(posedge CLK);
      #1;
      n++;
    end while (FLAGS.cmd_complete_flag !== 1'b1 && n < 3000);
    if (n >= 3000) begin
      errors++;
      stop_test();
    end
  endtask : run

  task automatic bad(input logic [7:0] code, input logic [6:0] blk, input logic [15:0] a,
                     input logic [15:0] b, input logic [2:0] idx, input logic sp,
                     input logic [2:0] av, input logic [15:0] exp);
    SPECIAL_MODE = sp;
    CMD_AVAIL = av;
    run(code, blk, a, b, idx);
    check(16'(FLAGS), exp);
    check(16'(nrd + nwr), 16'h0);
    SPECIAL_MODE = 1'b1;
    CMD_AVAIL = 3'h7;
  endtask : bad

  initial begin
    for (int i = 0; i < 2048; i++) begin
      mem[i] = ERASED_WORD;
    end
    repeat (8) @(posedge CLK);
    #1;
    RST = 1'b0;
    check(16'(FLAGS), 16'h0010);
    check({10'h0, PF_LEVEL, DF_LEVEL}, 16'h0000);
    // every margin setting on the data-flash block
    for (int s = 0; s < 5; s++) begin
      run(CMD_SET_FIELD_MARGIN, DF_BLOCK_ID, 16'(s), 16'h0, IDX_MARGIN);
      check(16'(DF_LEVEL), 16'(s));
      check({14'h0, BIAS_ERASED}, (s == 1 || s == 3) ? 16'h2 : 16'h0);
      check({14'h0, BIAS_PROG}, (s == 2 || s == 4) ? 16'h2 : 16'h0);
      check(16'(FLAGS), 16'h0010);
    end
    run(CMD_SET_FIELD_MARGIN, PF_BLOCK_ID, MARGIN_FIELD1, 16'h0, IDX_MARGIN);
    check({10'h0, PF_LEVEL, DF_LEVEL}, 16'h001c);
    check({12'h0, BIAS_ERASED, BIAS_PROG}, 16'h0006);
    bad(CMD_SET_FIELD_MARGIN, DF_BLOCK_ID, 16'h0005, 16'h0, 3'h1, 1'b1, 3'h7, 16'h0018);
    bad(CMD_SET_FIELD_MARGIN, DF_BLOCK_ID, 16'h0001, 16'h0, 3'h0, 1'b1, 3'h7, 16'h0018);
    bad(CMD_SET_FIELD_MARGIN, DF_BLOCK_ID, 16'h0001, 16'h0, 3'h2, 1'b1, 3'h7, 16'h0018);
    bad(CMD_SET_FIELD_MARGIN, 7'h05, 16'h0001, 16'h0, 3'h1, 1'b1, 3'h7, 16'h0018);
    bad(CMD_SET_FIELD_MARGIN, DF_BLOCK_ID, 16'h0001, 16'h0, 3'h1, 1'b0, 3'h7, 16'h0018);
    bad(CMD_SET_FIELD_MARGIN, DF_BLOCK_ID, 16'h0001, 16'h0, 3'h1, 1'b1, 3'h6, 16'h0018);
    // a code this block does not run is refused like an unavailable one
    bad(8'h12, DF_BLOCK_ID, 16'h0001, 16'h0, 3'h1, 1'b1, 3'h7, 16'h0018);
    check(16'(DF_LEVEL), 16'(FMDC_LVL_FIELD0));
    // erase verify up to the very last word, slow array
    lat = 3;
    run(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h0ff8, 16'h0004, IDX_COUNT);
    check(16'(FLAGS), 16'h0010);
    check(16'(nrd), 16'h0004);
    check(last_rd, 16'h0ffe);
    lat = 0;
    bad(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h0ff8, 16'h0005, 3'h2, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h0101, 16'h0001, 3'h2, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h1000, 16'h0001, 3'h2, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_ERASE_VERIFY, PF_BLOCK_ID, 16'h0000, 16'h0001, 3'h2, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h0000, 16'h0001, 3'h1, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h0000, 16'h0001, 3'h2, 1'b1, 3'h5, 16'h0018);
    mem[16] = 16'h0000;
    run(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h0000, 16'h0020, IDX_COUNT);
    check(16'(FLAGS), 16'h0012);
    check(16'(nrd), 16'h0020);
    err_inj = 1'b1;
    run(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h0040, 16'h0002, IDX_COUNT);
    check(16'(FLAGS), 16'h0012);
    fatal_inj = 1'b1;
    run(CMD_DF_ERASE_VERIFY, DF_BLOCK_ID, 16'h0040, 16'h0002, IDX_COUNT);
    check(16'(FLAGS), 16'h0013);
    err_inj = 1'b0;
    fatal_inj = 1'b0;
    // one to four words, slow and prompt array alternately
    for (int n = 1; n < 5; n++) begin
      lat = (n % 2) * 2;
      for (int k = 1; k < 4; k++) begin
        PARAM_ARRAY[2 + k] = 16'ha000 + 16'(n * 16 + k);
      end
      run(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'(256 + 16 * n), 16'ha000 + 16'(n * 16), 3'(n + 1));
      check(16'(nwr), 16'(n));
      check(16'(nrd), 16'(n));
      check(16'(FLAGS), 16'h0010);
      for (int k = 0; k < 4; k++) begin
        check(mem[128 + 8 * n + k], (k < n) ? 16'ha000 + 16'(n * 16 + k) : ERASED_WORD);
      end
    end
    lat = 0;
    bad(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'h0ffe, 16'h1234, 3'h3, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'h0300, 16'h1234, 3'h6, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'h0300, 16'h1234, 3'h1, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'h0301, 16'h1234, 3'h2, 1'b1, 3'h7, 16'h0018);
    bad(CMD_DF_PROGRAM, PF_BLOCK_ID, 16'h0300, 16'h1234, 3'h2, 1'b1, 3'h7, 16'h0018);
    DF_PROTECT = 8'h02;
    bad(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'h0200, 16'h1234, 3'h2, 1'b1, 3'h7, 16'h0014);
    bad(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'h01fe, 16'h1234, 3'h3, 1'b1, 3'h7, 16'h0014);
    bad(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'h0200, 16'h1234, 3'h2, 1'b1, 3'h3, 16'h0018);
    check(mem[256], ERASED_WORD);
    DF_PROTECT = 8'h00;
    err_inj = 1'b1;
    fatal_inj = 1'b1;
    run(CMD_DF_PROGRAM, DF_BLOCK_ID, 16'h0400, 16'h5a5a, IDX_WORD0);
    check(16'(FLAGS), 16'h0013);
    stop_test();
  end
endmodule : fmdc_seq_tb
